/* src/linefeed_voltage_power_regs.sv */
// Linefeed voltage target registers and transistor power monitor.
`timescale 1ns/100ps
module linefeed_voltage_power_regs
(
   input  wire logic       CORE_CLK,
   input  wire logic       RSTN,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic       REG_WR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_RD,
   output logic      [7:0] REG_RDATA,
   input  wire logic       MANUAL_DIFFERENTIAL_SELECT,
   input  wire logic       MANUAL_COMMON_MODE_SELECT,
   input  wire logic       TRACK_ENABLE,
   input  wire logic       AUTO_DIFF_SIGN,
   input  wire logic [5:0] AUTO_DIFF_MAG,
   input  wire logic [5:0] AUTO_CM_LEVEL,
   input  wire logic [5:0] BAT_REQUEST,
   input  wire logic [7:0] Q1_POWER,
   input  wire logic [7:0] Q2_POWER,
   input  wire logic [7:0] Q3_POWER,
   input  wire logic [7:0] Q4_POWER,
   input  wire logic [7:0] Q5_POWER,
   input  wire logic [7:0] Q6_POWER,
   output logic            DIFF_SIGN,
   output logic      [5:0] DIFF_MAG,
   output logic      [5:0] CM_LEVEL,
   output logic      [5:0] BAT_TARGET,
   output logic            READOUT_FINE
);

   // Software state: polarity plus magnitude, levels, and pointer.
   logic [6:0] onhook_ff;
   logic [6:0] nxt_onhook;
   logic [5:0] cmode_ff;
   logic [5:0] nxt_cmode;
   logic [5:0] high_bat_ff;
   logic [5:0] nxt_high_bat;
   logic [5:0] low_bat_ff;
   logic [5:0] nxt_low_bat;
   logic [2:0] pointer_ff;
   logic [2:0] nxt_pointer;

   // Readout and read data state.
   logic [7:0] readout_ff;
   logic [7:0] nxt_readout;
   logic       fine_ff;
   logic       nxt_fine;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   // Line drive command state.
   logic       diff_sign_ff;
   logic       nxt_diff_sign;
   logic [5:0] diff_mag_ff;
   logic [5:0] nxt_diff_mag;
   logic [5:0] cm_level_ff;
   logic [5:0] nxt_cm_level;
   logic [5:0] bat_ff;
   logic [5:0] nxt_bat;
   logic [5:0] bat_floor;

   // Register writes; reserved bits are dropped so they read back as zero.
   always_comb
   begin
      nxt_onhook   = onhook_ff;
      nxt_cmode    = cmode_ff;
      nxt_high_bat = high_bat_ff;
      nxt_low_bat  = low_bat_ff;
      nxt_pointer  = pointer_ff;
      if (REG_WR)
      begin
         case (REG_ADDR)
            linefeed_regs_pkg::ADDR_ONHOOK:
               nxt_onhook = REG_WDATA[6:0];   // R1 R2 R12
            linefeed_regs_pkg::ADDR_CMODE:
               nxt_cmode = REG_WDATA[5:0];    // R3 R12
            linefeed_regs_pkg::ADDR_HIGH_BAT:
               nxt_high_bat = REG_WDATA[5:0]; // R4 R12
            linefeed_regs_pkg::ADDR_LOW_BAT:
               nxt_low_bat = REG_WDATA[5:0];  // R5 R12
            linefeed_regs_pkg::ADDR_MON_SEL:
               nxt_pointer = REG_WDATA[2:0];  // R6 R12
            default:
               nxt_pointer = pointer_ff;      // R12
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         onhook_ff   <= linefeed_regs_pkg::RST_ONHOOK;
         cmode_ff    <= linefeed_regs_pkg::RST_CMODE;
         high_bat_ff <= linefeed_regs_pkg::RST_HIGH_BAT;
         low_bat_ff  <= linefeed_regs_pkg::RST_LOW_BAT;
         pointer_ff  <= linefeed_regs_pkg::RST_POINTER;
      end
      else
      begin
         onhook_ff   <= nxt_onhook;
         cmode_ff    <= nxt_cmode;
         high_bat_ff <= nxt_high_bat;
         low_bat_ff  <= nxt_low_bat;
         pointer_ff  <= nxt_pointer;
      end
   end

   // Power readout follows the pointer one cycle behind, so a read in the cycle
   // right after a pointer write sees the previous transistor. Undefined codes give a fixed value, not garbage.
   always_comb
   begin
      nxt_fine = 1'b0;
      case (pointer_ff)
         linefeed_regs_pkg::SEL_Q1: nxt_readout = Q1_POWER; // R6 R7
         linefeed_regs_pkg::SEL_Q2: nxt_readout = Q2_POWER; // R7
         linefeed_regs_pkg::SEL_Q3:
         begin
            nxt_readout = Q3_POWER; // R8
            nxt_fine    = 1'b1;     // R8
         end
         linefeed_regs_pkg::SEL_Q4:
         begin
            nxt_readout = Q4_POWER; // R8
            nxt_fine    = 1'b1;     // R8
         end
         linefeed_regs_pkg::SEL_Q5: nxt_readout = Q5_POWER; // R7
         linefeed_regs_pkg::SEL_Q6: nxt_readout = Q6_POWER; // R7
         default: nxt_readout = linefeed_regs_pkg::UNDEF_READOUT; // R6
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         readout_ff <= 8'h00;
         fine_ff    <= 1'b0;
      end
      else
      begin
         readout_ff <= nxt_readout;
         fine_ff    <= nxt_fine;
      end
   end

   // Read data is held until the next read; unmapped addresses give zero.
   always_comb
   begin
      nxt_rdata = rdata_ff;
      if (REG_RD)
      begin
         case (REG_ADDR)
            linefeed_regs_pkg::ADDR_ONHOOK:   nxt_rdata = {1'b0, onhook_ff};
            linefeed_regs_pkg::ADDR_CMODE:    nxt_rdata = {2'h0, cmode_ff};
            linefeed_regs_pkg::ADDR_HIGH_BAT: nxt_rdata = {2'h0, high_bat_ff};
            linefeed_regs_pkg::ADDR_LOW_BAT:  nxt_rdata = {2'h0, low_bat_ff};
            linefeed_regs_pkg::ADDR_MON_SEL:  nxt_rdata = {5'h00, pointer_ff};
            linefeed_regs_pkg::ADDR_READOUT:  nxt_rdata = readout_ff; // R7
            default:                          nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
         rdata_ff <= 8'h00;
      else
         rdata_ff <= nxt_rdata;
   end

   // Battery floor: a larger code is a more negative voltage. The high
   // target caps the result too, which also keeps a misprogrammed low
   // target from pushing the converter beyond the high setting.
   always_comb
   begin
      if (!TRACK_ENABLE && (BAT_REQUEST < low_bat_ff))
         bat_floor = low_bat_ff;                          // R11
      else
         bat_floor = BAT_REQUEST;
      if (bat_floor > high_bat_ff)
         nxt_bat = high_bat_ff;                           // R4
      else
         nxt_bat = bat_floor;
   end

   // Manual selects override the automatic loop with the software levels.
   always_comb
   begin
      if (MANUAL_DIFFERENTIAL_SELECT)
      begin
         nxt_diff_sign = onhook_ff[linefeed_regs_pkg::POLARITY_BIT]; // R1 R9
         nxt_diff_mag  = onhook_ff[5:0];                             // R2 R9
      end
      else
      begin
         nxt_diff_sign = AUTO_DIFF_SIGN;
         nxt_diff_mag  = AUTO_DIFF_MAG;
      end
      if (MANUAL_COMMON_MODE_SELECT)
         nxt_cm_level = cmode_ff;                         // R3 R10
      else
         nxt_cm_level = AUTO_CM_LEVEL;
   end

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         diff_sign_ff <= 1'b0;
         diff_mag_ff  <= 6'h00;
         cm_level_ff  <= 6'h00;
         bat_ff       <= 6'h00;
      end
      else
      begin
         diff_sign_ff <= nxt_diff_sign;
         diff_mag_ff  <= nxt_diff_mag;
         cm_level_ff  <= nxt_cm_level;
         bat_ff       <= nxt_bat;
      end
   end

   // Every output comes straight from a flip-flop.
   assign REG_RDATA    = rdata_ff;
   assign DIFF_SIGN    = diff_sign_ff;
   assign DIFF_MAG     = diff_mag_ff;
   assign CM_LEVEL     = cm_level_ff;
   assign BAT_TARGET   = bat_ff;
   assign READOUT_FINE = fine_ff;

   // Checks that tie outputs back to their causes.
   property p_polarity_write;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (REG_WR && REG_ADDR == linefeed_regs_pkg::ADDR_ONHOOK)
         |=> (onhook_ff[6] == $past(REG_WDATA[6]));
   endproperty
   a_polarity_write: assert property (p_polarity_write) // R1
      else $error("Polarity bit did not take the written value.");

   property p_manual_diff;
      @(posedge CORE_CLK) disable iff (!RSTN)
      MANUAL_DIFFERENTIAL_SELECT
         |=> (DIFF_MAG == $past(onhook_ff[5:0])
              && DIFF_SIGN == $past(onhook_ff[6]));
   endproperty
   a_manual_diff: assert property (p_manual_diff) // R9
      else $error("Manual differential does not follow on-hook field.");

   property p_manual_cm;
      @(posedge CORE_CLK) disable iff (!RSTN)
      MANUAL_COMMON_MODE_SELECT |=> (CM_LEVEL == $past(cmode_ff));
   endproperty
   a_manual_cm: assert property (p_manual_cm) // R10
      else $error("Manual common mode does not follow common-mode field.");

   property p_bat_floor;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (!TRACK_ENABLE && low_bat_ff <= high_bat_ff)
         |=> (BAT_TARGET >= $past(low_bat_ff));
   endproperty
   a_bat_floor: assert property (p_bat_floor) // R11
      else $error("Battery target fell below the low battery setting.");

   property p_bat_cap;
      @(posedge CORE_CLK) disable iff (!RSTN)
      1'b1 |=> (BAT_TARGET <= $past(high_bat_ff));
   endproperty
   a_bat_cap: assert property (p_bat_cap) // R4
      else $error("Battery target exceeded the high battery setting.");

   property p_readout_q1;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (pointer_ff == linefeed_regs_pkg::SEL_Q1)
         |=> (readout_ff == $past(Q1_POWER));
   endproperty
   a_readout_q1: assert property (p_readout_q1) // R7
      else $error("Readout does not follow transistor one power.");

   property p_fine_scale;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (pointer_ff == linefeed_regs_pkg::SEL_Q3 ||
       pointer_ff == linefeed_regs_pkg::SEL_Q4) |=> READOUT_FINE;
   endproperty
   a_fine_scale: assert property (p_fine_scale) // R8
      else $error("Fine scale flag missing for transistor three or four.");

   property p_undefined_ptr;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (pointer_ff > linefeed_regs_pkg::SEL_Q6)
         |=> (readout_ff == 8'h00 && !READOUT_FINE);
   endproperty
   a_undefined_ptr: assert property (p_undefined_ptr) // R6
      else $error("Undefined pointer code gave a nonzero readout.");

   property p_reserved_zero;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (REG_RD && REG_ADDR == linefeed_regs_pkg::ADDR_CMODE)
         |=> (REG_RDATA[7:6] == 2'h0 && REG_RDATA[5:0] == $past(cmode_ff));
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // R12
      else $error("Reserved bits of common mode read nonzero.");

   property p_lowbat_write;
      @(posedge CORE_CLK) disable iff (!RSTN)
      (REG_WR && REG_ADDR == linefeed_regs_pkg::ADDR_LOW_BAT)
         |=> (low_bat_ff == $past(REG_WDATA[5:0]));
   endproperty
   a_lowbat_write: assert property (p_lowbat_write) // R5
      else $error("Low battery field did not take the written value.");

endmodule

/* src/linefeed_regs_pkg.sv */
// Constants for the linefeed voltage and power monitor register bank.
// How it works
// R1 - Bit 6 picks on-hook polarity sign.
// R2 - Six-bit on-hook magnitude, 1.5 V steps, reset 48 V.
// R3 - Common-mode field sets tip or ring target.
// R4 - High battery target, reset -75 V, above low.
// R5 - Low battery target, reset -24 V.
// R6 - Pointer codes 0-5 pick transistors one-six.
// R7 - Readout continuously reports selected transistor power.
// R8 - Transistors three and four use fine scale.
// R9 - Manual differential follows on-hook magnitude field.
// R10 - Manual common mode follows common-mode field.
// R11 - Without tracking, battery never below low target; code caps it at the high target, so it falls below low when low exceeds high.
// R12 - Reserved bits read zero; readout ignores writes.
package linefeed_regs_pkg;

   // Register addresses on the control port.
   localparam logic [7:0] ADDR_ONHOOK   = 8'h48;
   localparam logic [7:0] ADDR_CMODE    = 8'h49;
   localparam logic [7:0] ADDR_HIGH_BAT = 8'h4A;
   localparam logic [7:0] ADDR_LOW_BAT  = 8'h4B;
   localparam logic [7:0] ADDR_MON_SEL  = 8'h4C;
   localparam logic [7:0] ADDR_READOUT  = 8'h4D;

   // Field positions and widths.
   localparam int POLARITY_BIT = 6;
   localparam int LEVEL_W      = 6;
   localparam int POINTER_W    = 3;
   localparam int POWER_W      = 8;

   // Reset values.
   localparam logic [6:0] RST_ONHOOK   = 7'h20;
   localparam logic [5:0] RST_CMODE    = 6'h02;
   localparam logic [5:0] RST_HIGH_BAT = 6'h32;
   localparam logic [5:0] RST_LOW_BAT  = 6'h10;
   localparam logic [2:0] RST_POINTER  = 3'h0;

   // Pointer codes for each transistor.
   localparam logic [2:0] SEL_Q1 = 3'h0;
   localparam logic [2:0] SEL_Q2 = 3'h1;
   localparam logic [2:0] SEL_Q3 = 3'h2;
   localparam logic [2:0] SEL_Q4 = 3'h3;
   localparam logic [2:0] SEL_Q5 = 3'h4;
   localparam logic [2:0] SEL_Q6 = 3'h5;

   // Readout shown for the two undefined pointer codes.
   localparam logic [7:0] UNDEF_READOUT = 8'h00;

endpackage

/* bench/testbench.sv */
// Self-checking testbench for the linefeed voltage and power register bank.
`timescale 1ns/100ps
module testbench;
   logic       core_clk;
   logic       rstn;
   logic [7:0] reg_addr;
   logic       reg_wr;
   logic [7:0] reg_wdata;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       man_diff;
   logic       man_cm;
   logic       track;
   logic       auto_sign;
   logic [5:0] auto_mag;
   logic [5:0] auto_cm;
   logic [5:0] bat_req;
   logic [7:0] qp [6];
   logic       diff_sign;
   logic [5:0] diff_mag;
   logic [5:0] cm_level;
   logic [5:0] bat_target;
   logic       readout_fine;
   logic [7:0] exp_q [$];
   logic       rd_seen = 1'b0;
   logic [7:0] mask [5] = '{8'h7F, 8'h3F, 8'h3F, 8'h3F, 8'h07};
   logic [7:0] v;
   logic [5:0] e;
   logic [6:0] d;
   int         n_mismatch = 0;
   int         samples_checked = 0;
   int         cycles = 0;
   int         seed = 29;

   linefeed_voltage_power_regs i_dut
   (
      .CORE_CLK                   (core_clk),
      .RSTN                       (rstn),
      .REG_ADDR                   (reg_addr),
      .REG_WR                     (reg_wr),
      .REG_WDATA                  (reg_wdata),
      .REG_RD                     (reg_rd),
      .REG_RDATA                  (reg_rdata),
      .MANUAL_DIFFERENTIAL_SELECT (man_diff),
      .MANUAL_COMMON_MODE_SELECT  (man_cm),
      .TRACK_ENABLE               (track),
      .AUTO_DIFF_SIGN             (auto_sign),
      .AUTO_DIFF_MAG              (auto_mag),
      .AUTO_CM_LEVEL              (auto_cm),
      .BAT_REQUEST                (bat_req),
      .Q1_POWER                   (qp[0]),
      .Q2_POWER                   (qp[1]),
      .Q3_POWER                   (qp[2]),
      .Q4_POWER                   (qp[3]),
      .Q5_POWER                   (qp[4]),
      .Q6_POWER                   (qp[5]),
      .DIFF_SIGN                  (diff_sign),
      .DIFF_MAG                   (diff_mag),
      .CM_LEVEL                   (cm_level),
      .BAT_TARGET                 (bat_target),
      .READOUT_FINE               (readout_fine)
   );

   // Free-running 10 MHz clock.
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic compare(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Output pins are levels, so they are checked apart from read data.
   task automatic check_output(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // Each strobe starts on a fresh falling edge, so strobes never merge.
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr    = 1'b0;
   endtask

   task automatic read_reg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      exp_q.push_back(exp);
      @(negedge core_clk);
      reg_rd   = 1'b0;
   endtask

   // Read data lands on the edge after the strobe; check it half a cycle on.
   always @(posedge core_clk)
      rd_seen <= reg_rd;
   always @(negedge core_clk)
      if (rd_seen === 1'b1 && exp_q.size() > 0)
         compare(reg_rdata, exp_q.pop_front());

   // A hang is cut short well beyond the expected two hundred or so cycles.
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial
   begin
      rstn = 1'b0;
      {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
      {man_diff, man_cm, track, auto_sign, auto_mag, auto_cm} = '0;
      bat_req = '0;
      foreach (qp[i]) qp[i] = 8'h00;
      tick(20);
      rstn = 1'b1;
      read_reg(8'h48, 8'h20);
      read_reg(8'h49, 8'h02);
      read_reg(8'h4A, 8'h32);
      read_reg(8'h4B, 8'h10);
      read_reg(8'h4C, 8'h00);
      read_reg(8'h47, 8'h00);
      read_reg(8'h4E, 8'h00);
      for (int i = 0; i < 5; i++) write_reg(8'(8'h48 + i), 8'hFF);
      for (int i = 0; i < 5; i++) read_reg(8'(8'h48 + i), mask[i]);
      write_reg(8'h4D, 8'h5A);
      tick(3);
      read_reg(8'h4D, linefeed_regs_pkg::UNDEF_READOUT);
      // Every pointer code, with fresh random powers on all transistors.
      for (int c = 0; c < 8; c++)
      begin
         foreach (qp[i]) qp[i] = 8'($random(seed));
         write_reg(8'h4C, 8'(c));
         tick(3);
         v = (c < 6) ? qp[c] : linefeed_regs_pkg::UNDEF_READOUT;
         read_reg(8'h4D, v);
         check_output({7'h00, readout_fine}, {7'h00, c == 2 || c == 3});
      end
      // Manual and automatic selection of the line commands.
      for (int k = 0; k < 4; k++)
      begin
         v = 8'($random(seed));
         write_reg(8'h48, v);
         write_reg(8'h49, v);
         {auto_sign, auto_mag, auto_cm} = 13'($random(seed));
         man_diff = k[0];
         man_cm   = k[1];
         tick(2);
         e = man_cm ? v[5:0] : auto_cm;
         d = man_diff ? v[6:0] : {auto_sign, auto_mag};
         check_output({1'b0, diff_sign, diff_mag}, {1'b0, d});
         check_output({2'b00, cm_level}, {2'b00, e});
      end
      // Software keeps the high target at or above the low target.
      write_reg(8'h4A, 8'h30);
      write_reg(8'h4B, 8'h12);
      for (int k = 0; k < 16; k++)
      begin
         bat_req = 6'($random(seed));
         track   = 1'($random(seed));
         tick(2);
         e = (!track && bat_req < 6'h12) ? 6'h12 : bat_req;
         e = (e > 6'h30) ? 6'h30 : e;
         check_output({2'b00, bat_target}, {2'b00, e});
      end
      tick(3);
      // A read whose answer never showed up would leave a note behind.
      check_output(8'(exp_q.size()), 8'h00);
      give_verdict();
   end
endmodule
